/* File: ott_monitor.sv */
// Port checker for the over-temperature assertion timer
`timescale 1ns/100ps
`default_nettype none
module ott_monitor #(
   parameter int unsigned STEP_CYCLES = 4
) (
   input wire logic       clk_sys,          // Clock
   input wire logic       sys_rst,          // Reset
   input wire logic       overtemp_signal_n,// Over-temp in
   input wire logic [7:0] reg_addr,         // Offset
   input wire logic       reg_wr,           // Write
   input wire logic [7:0] reg_wdata,        // Wdata
   input wire logic       reg_rd,           // Read
   input wire logic [7:0] reg_rdata,        // Rdata
   input wire logic       reg_rvalid,       // Valid
   input wire logic       overtime_irq_flag,// Irq set
   input wire logic       overtemp_active   // Active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("stray read valid");
   unmap_zero_a: assert property (reg_rd && reg_addr != 8'h79
      && reg_addr != 8'h7a |=> reg_rdata == 8'h00) else $error("unmapped");
   limit_rb_a: assert property (reg_wr && reg_addr == 8'h7a
      ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 8'h7a
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("limit readback");
   seen_set_a: assert property ($rose(overtemp_active)
      ##1 reg_rd && reg_addr == 8'h79 |=> reg_rdata == 8'h01)
      else $error("seen flag");
   active_trk_a: assert property ($fell(overtemp_signal_n)
      |=> overtemp_active) else $error("active late");
   irq_pulse_a: assert property (overtime_irq_flag
      |=> !overtime_irq_flag) else $error("irq not a pulse");
   hold_data_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
endmodule
bind ott_timer ott_monitor #(.STEP_CYCLES(STEP_CYCLES)) u_mon (.*);
`default_nettype wire

/* File: ott_pkg.sv */
// Constants shared by the over-temperature assertion timer
package ott_pkg;
   localparam logic [7:0] OTT_STATUS_OFFSET   = 8'h79;
   localparam logic [7:0] OTT_LIMIT_OFFSET    = 8'h7a;
   localparam logic [7:0] OTT_STATUS_RESET    = 8'h00;
   localparam logic [7:0] OTT_LIMIT_RESET     = 8'h00;
   localparam logic [7:0] OTT_UNMAPPED_DATA   = 8'h00;
   localparam int unsigned OTT_FLAG_BIT       = 0;
   localparam int unsigned OTT_CNT_W          = 8;
   localparam logic [7:0] OTT_CNT_MAX         = 8'hff;
   // Duration must exceed this many steps before the count is shown
   localparam logic [7:0] OTT_REPORT_STEPS    = 8'h02;
   localparam logic [7:0] OTT_LIMIT_IMMEDIATE = 8'h00;
   // One count step is 22.76 ms
   localparam int unsigned OTT_STEP_NS        = 22760000;
   localparam int unsigned OTT_CLK_PERIOD_NS  = 50;
   localparam int unsigned OTT_STEP_CYCLES    =
      OTT_STEP_NS / OTT_CLK_PERIOD_NS;
   localparam int unsigned OTT_DIV_W          = 19;
endpackage

/* File: ott_src.sv */
// Far-side model: holds over-temp asserted for a set span
`timescale 1ns/100ps
`default_nettype none
module ott_src (
   input  wire logic        clk_sys, // Clock
   input  wire logic        go,      // Start pulse
   input  wire logic [15:0] len,     // Cycles held asserted
   output var  logic        hot_n    // Over-temp, active low
);
   logic [15:0] n = 16'h0;
   always_ff @(posedge clk_sys)
      n <= go ? len : (n != 16'h0 ? n - 16'h1 : n);
   assign hot_n = (n == 16'h0);
endmodule
`default_nettype wire

/* File: ott_step_div.sv */
// Step divider: one-cycle enable every step while the timer runs
`timescale 1ns/100ps
`default_nettype none
module ott_step_div #(
   parameter int unsigned STEP_CYCLES = ott_pkg::OTT_STEP_CYCLES
) (
   input  wire logic clk_sys,   // System clock
   input  wire logic sys_rst,   // Async reset, active high
   input  wire logic run,       // Count while high, restart when low
   output var  logic step       // One-cycle step enable
);
   import ott_pkg::*;

   localparam logic [OTT_DIV_W-1:0] LAST =
      OTT_DIV_W'(STEP_CYCLES - 1);

   typedef struct packed {
      logic [OTT_DIV_W-1:0] div;
      logic                 step;
   } ott_div_state_t;

   ott_div_state_t st_reg;
   ott_div_state_t st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.step = 1'b0;
      if (!run) begin
         // Restart so each assertion is timed from its own start
         st_next.div = '0;
      end else if (st_reg.div == LAST) begin
         st_next.div  = '0;
         st_next.step = 1'b1;
      end else begin
         st_next.div = st_reg.div + OTT_DIV_W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign step = st_reg.step;
endmodule
`default_nettype wire

/* File: ott_timer.sv */
// Over-temperature assertion timer with status and limit registers
`timescale 1ns/100ps
`default_nettype none
module ott_timer #(
   parameter int unsigned STEP_CYCLES = ott_pkg::OTT_STEP_CYCLES
) (
   input  wire logic       clk_sys,          // System clock, 20 MHz
   input  wire logic       sys_rst,          // Async reset, active high
   input  wire logic       overtemp_signal_n,// Over-temp input, active low
   input  wire logic [7:0] reg_addr,         // Register offset
   input  wire logic       reg_wr,           // Write strobe, one cycle
   input  wire logic [7:0] reg_wdata,        // Write data
   input  wire logic       reg_rd,           // Read strobe, one cycle
   output var  logic [7:0] reg_rdata,        // Read data
   output var  logic       reg_rvalid,       // Read data valid pulse
   output var  logic       overtime_irq_flag,// Pulse: set overtime flag
   output var  logic       overtemp_active   // Input currently asserted
);
   import ott_pkg::*;

   typedef struct packed {
      logic [OTT_CNT_W-1:0] cnt;
      logic                 seen;
      logic [7:0]           limit;
      logic                 active;
      logic                 fired;
      logic [7:0]           rdata;
      logic                 rvalid;
      logic                 irq;
   } ott_state_t;

   ott_state_t st_reg;
   ott_state_t st_next;

   logic       asserted;
   logic       rise;
   logic       step;
   logic [7:0] status_view;
   logic       over_limit;

   assign asserted = ~overtemp_signal_n;
   assign rise     = asserted & ~st_reg.active;

   ott_step_div #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_step_div (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .run     (asserted),
      .step    (step)
   );

   // Short assertions show only the seen flag in bit 0
   always_comb begin
      if (st_reg.cnt > OTT_REPORT_STEPS) begin
         status_view = st_reg.cnt;
      end else begin
         status_view = {7'h00, st_reg.seen};
      end
   end

   // Limit zero fires on the assertion itself
   always_comb begin
      if (st_reg.limit == OTT_LIMIT_IMMEDIATE) begin
         over_limit = asserted;
      end else begin
         over_limit = st_reg.active
                      && (st_reg.cnt > st_reg.limit);
      end
   end

   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = 1'b0;
      st_next.irq    = 1'b0;
      st_next.active = asserted;

      // Duration count
      if (rise) begin
         st_next.cnt   = '0;
         st_next.fired = 1'b0;
      end else if (st_reg.active && step
                   && st_reg.cnt != OTT_CNT_MAX) begin
         st_next.cnt = st_reg.cnt + OTT_CNT_W'(1);
      end

      // Register reads; the clear only touches the seen flag
      if (reg_rd) begin
         st_next.rvalid = 1'b1;
         if (reg_addr == OTT_STATUS_OFFSET) begin
            st_next.rdata = status_view;
            st_next.seen  = 1'b0;
         end else if (reg_addr == OTT_LIMIT_OFFSET) begin
            st_next.rdata = st_reg.limit;
         end else begin
            st_next.rdata = OTT_UNMAPPED_DATA;
         end
      end

      // New assertion wins over a clear in the same cycle
      if (rise) begin
         st_next.seen = 1'b1;
      end

      // Status offset takes no writes
      if (reg_wr && reg_addr == OTT_LIMIT_OFFSET) begin
         st_next.limit = reg_wdata;
      end

      // One notice per assertion keeps the flag from being re-hit
      if (over_limit && (rise ? 1'b1 : !st_reg.fired)) begin
         st_next.irq   = 1'b1;
         st_next.fired = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg        <= '0;
         st_reg.cnt    <= OTT_STATUS_RESET;
         st_reg.limit  <= OTT_LIMIT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata         = st_reg.rdata;
   assign reg_rvalid        = st_reg.rvalid;
   assign overtime_irq_flag = st_reg.irq;
   assign overtemp_active   = st_reg.active;
endmodule
`default_nettype wire

/* File: testbench.sv */
// Testbench for the over-temperature assertion timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_rd = 1'b0;
   logic        go = 1'b0;
   logic [15:0] len = 16'h0;
   logic        hot_n, rv, irq, act;
   logic [7:0]  rdata;
   int          n_fail = 0, check_count = 0, n_irq = 0;
   ott_timer #(.STEP_CYCLES(4)) uut (.clk_sys, .sys_rst,
      .overtemp_signal_n(hot_n), .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata(rdata), .reg_rvalid(rv), .overtime_irq_flag(irq),
      .overtemp_active(act));
   ott_src src (.clk_sys, .go, .len, .hot_n);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (irq === 1'b1) n_irq++;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk({7'h0, rv}, 8'h01);
      chk(rdata, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Assert over-temp for l cycles; task then waits one more edge
   task automatic hot(input logic [7:0] lim, input logic [15:0] l);
      wr(8'h7a, lim);
      n_irq = 0;
      @(posedge clk_sys);
      go <= 1'b1;
      len <= l;
      @(posedge clk_sys);
      go <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic t_regs();
      rd(8'h79, 8'h00);
      rd(8'h7a, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'h7a, 8'ha5);
      rd(8'h7a, 8'ha5);
      wr(8'h79, 8'hff);
      rd(8'h79, 8'h00);
   endtask
   task automatic t_seen();
      hot(8'h00, 16'd11);
      rd(8'h79, 8'h01);
      repeat (20) @(posedge clk_sys);
      chk(n_irq[7:0], 8'h01);
      rd(8'h79, 8'h00);
   endtask
   task automatic t_count();
      hot(8'h02, 16'd39);
      repeat (50) @(posedge clk_sys);
      rd(8'h79, 8'h09);
      chk(n_irq[7:0], 8'h01);
   endtask
   task automatic t_sat();
      hot(8'hff, 16'd1100);
      repeat (1110) @(posedge clk_sys);
      rd(8'h79, 8'hff);
      chk(n_irq[7:0], 8'h00);
   endtask
   task automatic conclude();
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs();
      t_seen();
      t_count();
      t_sat();
      conclude();
   end
endmodule
`default_nettype wire
